/* src/card_host_pkg.sv */
package card_host_pkg;
  // Bus cycle kinds the host can issue
  typedef enum logic [3:0] {
    OP_MEM_BYTE_RD, OP_MEM_BYTE_WR, OP_MEM_WORD_RD, OP_MEM_WORD_WR,
    OP_MEM_ODD_RD, OP_MEM_ODD_WR, OP_IDE_TF_RD, OP_IDE_TF_WR,
    OP_IDE_PIO_RD, OP_IDE_PIO_WR, OP_IDE_CTL_RD, OP_IDE_CTL_WR,
    OP_IDE_DMA_RD, OP_IDE_DMA_WR
  } op_t;

  localparam int ADDR_W          = 11;
  localparam int DATA_W          = 16;
  // Strobe timing, nanoseconds as specified
  localparam int CLK_NS          = 100;
  localparam int SETUP_NS        = 100;
  localparam int STROBE_NS       = 300;
  localparam int HOLD_NS         = 100;
  localparam int SETUP_CYC       = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC        = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Power-up mode capture: -OE held low this long selects true IDE
  localparam int PWR_NS          = 1000;
  localparam int PWR_CYC         = (PWR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] TF_FIRST = 3'h1;
  localparam logic [2:0] CTL_ALT  = 3'h6;
  localparam logic [2:0] CTL_DRV  = 3'h7;
  localparam logic [2:0] PIO_DATA = 3'h0;
  // Configuration index address bases
  localparam logic [10:0] MEM_DUP_BASE = 11'h400;
  localparam logic [10:0] PRI_BASE     = 11'h1F0;
  localparam logic [10:0] PRI_CTL      = 11'h3F6;
  localparam logic [10:0] SEC_BASE     = 11'h170;
  localparam logic [10:0] SEC_CTL      = 11'h376;
  localparam logic [1:0]  CFG_MEM      = 2'h0;
  localparam logic [1:0]  CFG_CONTIG   = 2'h1;
  localparam logic [1:0]  CFG_PRI      = 2'h2;
  localparam logic [1:0]  CFG_SEC      = 2'h3;
endpackage

/* src/strobe_if.sv */
`timescale 1ns/10ps
interface strobe_if;
  logic start;
  logic busy;
  logic step_setup;
  logic step_strobe;
  logic step_done;
  modport ctrl (output start, input busy, step_setup, step_strobe, step_done);
  modport tmr  (input start, output busy, step_setup, step_strobe, step_done);
endinterface

/* src/strobe_timer.sv */
`timescale 1ns/10ps
module strobe_timer
  import card_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  strobe_if.tmr    sif
);
  typedef enum logic [1:0] {T_IDLE, T_SETUP, T_STROBE, T_HOLD} tph_t;
  tph_t       ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d;

  // Sequence setup, strobe and hold phases of one bus cycle
  always_comb begin
    ph_d  = ph_q;
    cnt_d = cnt_q;
    sif.step_setup  = 1'b0;
    sif.step_strobe = 1'b0;
    sif.step_done   = 1'b0;
    unique case (ph_q)
      T_IDLE: if (sif.start) begin
        ph_d  = T_SETUP;
        cnt_d = 4'(SETUP_CYC);
      end
      T_SETUP: if (cnt_q == 4'h1) begin
        ph_d  = T_STROBE;
        // One fixed slow cycle, never an advanced mode, so any card mix is safe
        cnt_d = 4'(STROBE_CYC);
        sif.step_setup = 1'b1;
      end else cnt_d = cnt_q - 4'h1;
      T_STROBE: if (cnt_q == 4'h1) begin
        ph_d  = T_HOLD;
        cnt_d = 4'(HOLD_CYC);
        sif.step_strobe = 1'b1;
      end else cnt_d = cnt_q - 4'h1;
      T_HOLD: if (cnt_q == 4'h1) begin
        ph_d = T_IDLE;
        sif.step_done = 1'b1;
      end else cnt_d = cnt_q - 4'h1;
    endcase
    sif.busy = (ph_q != T_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q  <= T_IDLE;
      cnt_q <= 4'h0;
    end else begin
      ph_q  <= ph_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // strobe_timer

/* src/card_bus_host.sv */
`timescale 1ns/10ps
module card_bus_host
  import card_host_pkg::*;
#(
  parameter int PWR_HOLD = PWR_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Request side
  input  wire logic                          req_valid,
  input  wire card_host_pkg::op_t            req_op,
  input  wire logic [card_host_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [card_host_pkg::DATA_W-1:0] req_wdata,
  input  wire logic [1:0]                    cfg_index,
  input  wire logic                          power_up,
  input  wire logic                          ide_select,
  output logic                               req_ready,
  output logic                               rsp_valid,
  output logic [card_host_pkg::DATA_W-1:0]   rsp_rdata,
  output logic                               ide_mode,
  output logic                               card_power,
  // Card pins
  output logic [card_host_pkg::ADDR_W-1:0]   addr,
  output logic                               reg_n,
  output logic                               ce1_n,
  output logic                               ce2_n,
  output logic                               oe_n,
  output logic                               we_n,
  output logic                               iord_n,
  output logic                               iowr_n,
  output logic                               dmack_n,
  output logic [card_host_pkg::DATA_W-1:0]   d_out,
  output logic [1:0]                         d_oe,
  input  wire logic [card_host_pkg::DATA_W-1:0] d_in
);
  import card_host_pkg::*;

  typedef enum logic [1:0] {S_OFF, S_PWR, S_IDLE, S_CYCLE} st_t;

  strobe_if sif ();
  strobe_timer u_tmr (.clk(clk), .rst(rst), .sif(sif));

  st_t              st_q, st_d;
  logic [15:0]      pwr_q, pwr_d;
  logic             ide_q, ide_d;
  logic             pow_q, pow_d;
  op_t              op_q, op_d;
  logic [10:0]      addr_q, addr_d;
  logic [15:0]      wd_q, wd_d;
  logic [15:0]      rd_q, rd_d;
  logic             rv_q, rv_d;
  logic             rdy_q, rdy_d;
  logic             reg_q, reg_d, ce1_q, ce1_d, ce2_q, ce2_d;
  logic             oe_q, oe_d, we_q, we_d, iord_q, iord_d, iowr_q, iowr_d, dmack_q, dmack_d;
  logic [1:0]       doe_q, doe_d;
  logic             is_rd, is_mem, in_strobe;
  logic             req_mem, take;

  // Map a register offset onto the window of the current configuration; IRQ routing stays with the system
  function automatic logic [10:0] map_addr(input logic [1:0] ci, input logic [10:0] a);
    logic [10:0] r;
    r = a;
    unique case (ci)
      CFG_MEM:    r = a[10] ? (MEM_DUP_BASE | {1'b0, a[9:0]}) : {7'h00, a[3:0]};
      CFG_CONTIG: r = {a[10:4], a[3:0]};
      CFG_PRI:    r = (a[3:0] >= 4'hE) ? (PRI_CTL | {10'h000, a[0]})
                                       : (PRI_BASE | {8'h00, a[2:0]});
      CFG_SEC:    r = (a[3:0] >= 4'hE) ? (SEC_CTL | {10'h000, a[0]})
                                       : (SEC_BASE | {8'h00, a[2:0]});
    endcase
    return r;
  endfunction

  // A request reaches the pins only when sequencer and timer are idle and the op
  // belongs to the current mode; a refused op must not start the timer, or its
  // phantom phases would clip the strobe of the next real cycle
  assign req_mem   = (req_op inside {OP_MEM_BYTE_RD, OP_MEM_BYTE_WR, OP_MEM_WORD_RD,
                                     OP_MEM_WORD_WR, OP_MEM_ODD_RD, OP_MEM_ODD_WR});
  assign take      = (st_q == S_IDLE) && power_up && req_valid && rdy_q && !sif.busy && (ide_q != req_mem);
  assign sif.start = take;

  // Main sequencer: power-up strap, cycle setup and pin steering
  always_comb begin
    st_d = st_q; pwr_d = pwr_q; ide_d = ide_q; pow_d = pow_q;
    op_d = op_q; addr_d = addr_q; wd_d = wd_q; rd_d = rd_q;
    rv_d = 1'b0; rdy_d = rdy_q;
    reg_d = reg_q; ce1_d = ce1_q; ce2_d = ce2_q; oe_d = oe_q; we_d = we_q;
    iord_d = iord_q; iowr_d = iowr_q; dmack_d = dmack_q; doe_d = doe_q;
    is_rd  = (op_q inside {OP_MEM_BYTE_RD, OP_MEM_WORD_RD, OP_MEM_ODD_RD, OP_IDE_TF_RD,
                           OP_IDE_PIO_RD, OP_IDE_CTL_RD, OP_IDE_DMA_RD});
    is_mem = (op_q inside {OP_MEM_BYTE_RD, OP_MEM_BYTE_WR, OP_MEM_WORD_RD,
                           OP_MEM_WORD_WR, OP_MEM_ODD_RD, OP_MEM_ODD_WR});
    in_strobe = 1'b0;
    unique case (st_q)
      S_OFF: if (power_up) begin
        // Card power off to on: -OE grounded for the whole ramp selects IDE
        st_d  = S_PWR;
        pow_d = 1'b1;
        pwr_d = 16'(PWR_HOLD);
        ide_d = ide_select;
        oe_d  = ~ide_select;
      end
      S_PWR: if (!power_up) begin
        st_d = S_OFF; pow_d = 1'b0; ide_d = 1'b0; oe_d = 1'b1;
      end else if (pwr_q == 16'h0001) begin
        st_d = S_IDLE; oe_d = 1'b1; rdy_d = 1'b1;
      end else pwr_d = pwr_q - 16'h0001;
      S_IDLE: if (!power_up) begin
        st_d = S_OFF; pow_d = 1'b0; ide_d = 1'b0; rdy_d = 1'b0;
      end else if (req_valid && (ide_q == req_mem)) begin
        // True IDE never reaches memory space; PC Card never uses DMACK.
        // Refused ops leave every pin where it was and answer next cycle.
        rv_d = 1'b1; rd_d = 16'hFFFF;
      end else if (take) begin
        st_d = S_CYCLE; rdy_d = 1'b0;
        op_d = req_op;
        // Odd-only writes put their byte on the high lane, held in a register
        wd_d = (req_op == OP_MEM_ODD_WR) ? {req_wdata[7:0], 8'h00} : req_wdata;
        addr_d = ide_q ? req_addr : map_addr(cfg_index, req_addr);
        // Address, card enables and chip selects go out during setup
        reg_d = 1'b1; ce1_d = 1'b1; ce2_d = 1'b1; dmack_d = 1'b1;
        unique case (req_op)
          OP_MEM_BYTE_RD, OP_MEM_BYTE_WR: ce1_d = 1'b0;
          OP_MEM_WORD_RD, OP_MEM_WORD_WR: begin ce1_d = 1'b0; ce2_d = 1'b0; end
          OP_MEM_ODD_RD, OP_MEM_ODD_WR:   ce2_d = 1'b0;
          OP_IDE_TF_RD, OP_IDE_TF_WR:
            begin ce1_d = 1'b0; addr_d = {8'h00, (req_addr[2:0] == PIO_DATA) ? TF_FIRST : req_addr[2:0]}; end
          OP_IDE_PIO_RD, OP_IDE_PIO_WR:
            begin ce1_d = 1'b0; addr_d = {8'h00, PIO_DATA}; end
          OP_IDE_CTL_RD, OP_IDE_CTL_WR:
            begin ce2_d = 1'b0; addr_d = {8'h00, (req_op == OP_IDE_CTL_WR) ? CTL_ALT : req_addr[2:0]}; end
          OP_IDE_DMA_WR: begin ce1_d = 1'b0; dmack_d = 1'b0; end
          OP_IDE_DMA_RD: dmack_d = 1'b0;
          default: ;
        endcase
      end
      S_CYCLE: begin
        if (sif.step_setup) in_strobe = 1'b1;
        if (in_strobe) begin
          if (is_rd) begin
            if (is_mem) oe_d = 1'b0; else iord_d = 1'b0;
          end else begin
            if (is_mem) we_d = 1'b0; else iowr_d = 1'b0;
            // Drive only the lanes the card samples on this cycle
            doe_d = (op_q inside {OP_MEM_WORD_WR, OP_IDE_PIO_WR, OP_IDE_DMA_WR}) ? 2'b11 :
                    (op_q == OP_MEM_ODD_WR) ? 2'b10 : 2'b01;
          end
        end
        if (sif.step_strobe) begin
          // Capture on the strobe's trailing edge, card still driving
          unique case (op_q)
            OP_MEM_ODD_RD:  rd_d = {8'h00, d_in[15:8]};
            OP_MEM_WORD_RD, OP_IDE_PIO_RD, OP_IDE_DMA_RD: rd_d = d_in;
            default:        rd_d = {8'h00, d_in[7:0]};
          endcase
          oe_d = 1'b1; we_d = 1'b1; iord_d = 1'b1; iowr_d = 1'b1;
        end
        if (sif.step_done) begin
          ce1_d = 1'b1; ce2_d = 1'b1; dmack_d = 1'b1; doe_d = 2'b00;
          st_d = S_IDLE; rdy_d = 1'b1; rv_d = 1'b1;
          if (!is_rd) rd_d = 16'h0000;
        end
      end
    endcase
  end

  // Register everything that leaves the block
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= S_OFF; pwr_q <= 16'h0000; ide_q <= 1'b0; pow_q <= 1'b0;
      op_q <= OP_MEM_BYTE_RD; addr_q <= 11'h000; wd_q <= 16'h0000; rd_q <= 16'h0000;
      rv_q <= 1'b0; rdy_q <= 1'b0;
      reg_q <= 1'b1; ce1_q <= 1'b1; ce2_q <= 1'b1; oe_q <= 1'b1; we_q <= 1'b1;
      iord_q <= 1'b1; iowr_q <= 1'b1; dmack_q <= 1'b1; doe_q <= 2'b00;
    end else begin
      st_q <= st_d; pwr_q <= pwr_d; ide_q <= ide_d; pow_q <= pow_d;
      op_q <= op_d; addr_q <= addr_d; wd_q <= wd_d; rd_q <= rd_d;
      rv_q <= rv_d; rdy_q <= rdy_d;
      reg_q <= reg_d; ce1_q <= ce1_d; ce2_q <= ce2_d; oe_q <= oe_d; we_q <= we_d;
      iord_q <= iord_d; iowr_q <= iowr_d; dmack_q <= dmack_d; doe_q <= doe_d;
    end
  end

  // Write data is lane-placed when the request is taken, so the pins come from flops
  assign d_out      = wd_q;
  assign addr       = addr_q;
  assign reg_n      = reg_q;
  assign ce1_n      = ce1_q;
  assign ce2_n      = ce2_q;
  assign oe_n       = oe_q;
  assign we_n       = we_q;
  assign iord_n     = iord_q;
  assign iowr_n     = iowr_q;
  assign dmack_n    = dmack_q;
  assign d_oe       = doe_q;
  assign req_ready  = rdy_q;
  assign rsp_valid  = rv_q;
  assign rsp_rdata  = rd_q;
  assign ide_mode   = ide_q;
  assign card_power = pow_q;
endmodule // card_bus_host

/* test/card_model.sv */
`timescale 1ns/10ps
module card_model
  import card_host_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              card_power,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, dmack_n,
  input  wire logic [DATA_W-1:0] d_out,
  output logic      [DATA_W-1:0] d_in
);
  logic [7:0]        mem_q [16];
  logic [DATA_W-1:0] last_q = '0;
  logic              ide_q, seen_q, lo_en, hi_en, rd, wr;
  logic [3:0]        lo_i, hi_i;
  // Mode is fixed by the enable level in the first powered cycle
  always_ff @(posedge clk) begin
    if (!card_power) begin
      ide_q  <= 1'b1;
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
      if (!seen_q && oe_n) ide_q <= 1'b0;
    end
  end
  // Lane steering; PC strobes are ignored in IDE mode and I/O strobes in PC mode
  always_comb begin
    lo_i  = {addr[3:1], 1'b0};
    hi_i  = {addr[3:1], 1'b1};
    lo_en = 1'b0;
    hi_en = 1'b0;
    if (!ide_q) begin
      if (reg_n) begin
        lo_en = !ce1_n;
        hi_en = !ce2_n;
        if (ce2_n) lo_i = addr[3:0];
      end
    end else if (!dmack_n) begin
      lo_i  = 4'h0;
      hi_i  = 4'h1;
      lo_en = 1'b1;
      hi_en = 1'b1;
    end else if (!ce1_n && ce2_n) begin
      lo_en = 1'b1;
      hi_en = (addr[2:0] == 3'h0);
      lo_i  = {1'b0, addr[2:0]};
      hi_i  = 4'h1;
    end else if (ce1_n && !ce2_n) begin
      lo_en = 1'b1;
      lo_i  = {1'b1, addr[2:0]};
    end
    rd = ide_q ? !iord_n : !oe_n;
    wr = ide_q ? !iowr_n : !we_n;
  end
  // A released lane toggles every cycle so stale data never looks valid
  assign d_in[7:0]  = (rd && lo_en) ? mem_q[lo_i] : ~last_q[7:0];
  assign d_in[15:8] = (rd && hi_en) ? mem_q[hi_i] : ~last_q[15:8];
  always_ff @(posedge clk) begin
    last_q <= d_in;
    if (wr && lo_en) mem_q[lo_i] <= d_out[7:0];
    if (wr && hi_en) mem_q[hi_i] <= d_out[15:8];
  end
endmodule // card_model

/* test/bus_host_sva.sv */
`timescale 1ns/10ps
module bus_host_sva (
  input wire logic        clk, rst, req_valid, req_ready, rsp_valid, ide_mode, card_power,
  input wire logic [15:0] rsp_rdata,
  input wire logic [10:0] addr,
  input wire logic        reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, dmack_n,
  input wire logic [1:0]  d_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Lane enables follow the card enable pattern of each memory write kind and are off when idle
  idle_lanes_a: assert property (ce1_n && ce2_n && dmack_n |-> d_oe == 2'h0) else $error("lanes driven idle");
  word_lanes_a: assert property (!we_n && !ce1_n && !ce2_n |-> d_oe == 2'h3) else $error("word lanes");
  byte_lane_a: assert property (!we_n && !ce1_n && ce2_n |-> d_oe == 2'h1 && reg_n) else $error("byte lane");
  odd_lane_a: assert property (!we_n && ce1_n && !ce2_n |-> d_oe == 2'h2) else $error("odd lane");
  ide_no_mem_a: assert property (ide_mode |-> we_n) else $error("memory write in IDE mode");
  pc_no_io_a: assert property (!ide_mode |-> iord_n && iowr_n && dmack_n) else $error("I/O in PC mode");
  dma_rd_cs_a: assert property (!dmack_n && !iord_n |-> ce1_n && ce2_n) else $error("DMA read selects");
  dma_wr_cs_a: assert property (!dmack_n && !iowr_n |-> !ce1_n && ce2_n) else $error("DMA write selects");
  one_select_a: assert property (ide_mode |-> ce1_n || ce2_n) else $error("both selects low");
  ctl_addr_a: assert property (!ce2_n && ce1_n && !iowr_n |-> addr[2:0] == 3'h6) else $error("control addr");
  strobe_len_a: assert property ($fell(we_n) |-> (!we_n)[*3] ##1 we_n) else $error("strobe length");
  ide_strap_a: assert property ($rose(card_power) |-> oe_n == !ide_mode) else $error("power-up strap");
  off_pc_mode_a: assert property (!card_power |-> !ide_mode) else $error("IDE mode without power");
  answer_time_a: assert property (req_valid && req_ready |->
    (##1 rsp_valid ##0 rsp_rdata == 16'hFFFF) or (##6 rsp_valid)) else $error("answer timing");
endmodule // bus_host_sva
bind card_bus_host bus_host_sva u_sva (.clk, .rst, .req_valid, .req_ready, .rsp_valid, .ide_mode, .rsp_rdata,
  .addr, .reg_n, .ce1_n, .ce2_n, .oe_n, .we_n, .iord_n, .iowr_n, .dmack_n, .d_oe, .card_power);

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import card_host_pkg::*;
  logic        clk = 0, rst = 1, req_valid = 0, power_up = 0, ide_select = 0;
  op_t         req_op = OP_MEM_BYTE_RD;
  logic [10:0] req_addr = '0, addr;
  logic [15:0] req_wdata = '0, rsp_rdata, d_out, d_in, r;
  logic [1:0]  cfg_index = 2'h0, d_oe;
  logic        req_ready, rsp_valid, ide_mode, card_power, reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, dmack_n;
  int          failures = 0, check_count = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  card_bus_host #(.PWR_HOLD(2)) u_dut (.clk, .rst, .req_valid, .req_op, .req_addr, .req_wdata, .cfg_index,
    .power_up, .ide_select, .req_ready, .rsp_valid, .rsp_rdata, .ide_mode, .card_power, .addr, .reg_n,
    .ce1_n, .ce2_n, .oe_n, .we_n, .iord_n, .iowr_n, .dmack_n, .d_out, .d_oe, .d_in);
  card_model u_card (.clk, .card_power, .addr, .reg_n, .ce1_n, .ce2_n, .oe_n, .we_n, .iord_n, .iowr_n,
    .dmack_n, .d_out, .d_in);
  task end_sim;
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus cycle: request held until taken, answer caught in its single cycle
  task op_run(op_t o, logic [10:0] a, logic [15:0] w, output logic [15:0] q);
    int i;
    @(negedge clk);
    req_op = o; req_addr = a; req_wdata = w; req_valid = 1'b1;
    i = 0;
    // Ready is read between edges, so the rising edge after this is the take
    while (req_ready !== 1'b1 && i < 50) begin @(negedge clk); i++; end
    if (req_ready !== 1'b1) begin failures++; end_sim; end
    @(negedge clk);
    req_valid = 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 20) begin @(negedge clk); i++; end
    if (rsp_valid !== 1'b1) begin failures++; end_sim; end
    q = rsp_rdata;
  endtask
  // Power cycle the card, optionally asking for true IDE mode
  task pwr(logic ide);
    int i;
    @(negedge clk);
    power_up = 1'b0;
    repeat (5) @(negedge clk);
    ide_select = ide;
    power_up = 1'b1;
    i = 0;
    while (req_ready !== 1'b1 && i < 40) begin @(negedge clk); i++; end
    if (req_ready !== 1'b1) begin failures++; end_sim; end
    chk("ide_mode", {15'h0, ide}, {15'h0, ide_mode});
  endtask
  task pc_lanes;
    op_run(OP_MEM_WORD_WR, 11'h0, 16'hA55A, r);
    op_run(OP_MEM_BYTE_WR, 11'h2, 16'h003C, r);
    op_run(OP_MEM_ODD_WR, 11'h3, 16'h00C3, r);
    op_run(OP_MEM_WORD_RD, 11'h2, 16'h0, r);
    chk("word read", 16'hC33C, r);
    op_run(OP_MEM_BYTE_RD, 11'h1, 16'h0, r);
    chk("odd byte read", 16'h00A5, r);
    op_run(OP_MEM_ODD_RD, 11'h0, 16'h0, r);
    chk("odd only read", 16'h00A5, r);
    op_run(OP_MEM_WORD_RD, 11'h1, 16'h0, r);
    chk("word read a0 set", 16'hA55A, r);
    op_run(OP_IDE_PIO_RD, 11'h0, 16'h0, r);
    chk("ide op in pc mode", 16'hFFFF, r);
  endtask
  task ide_paths;
    pwr(1'b1);
    op_run(OP_MEM_WORD_RD, 11'h0, 16'h0, r);
    chk("memory op in ide mode", 16'hFFFF, r);
    op_run(OP_IDE_TF_WR, 11'h2, 16'h0077, r);
    op_run(OP_IDE_TF_RD, 11'h2, 16'h0, r);
    chk("task file read", 16'h0077, r);
    op_run(OP_IDE_PIO_WR, 11'h0, 16'h1234, r);
    op_run(OP_IDE_DMA_RD, 11'h5, 16'h0, r);
    chk("dma read", 16'h1234, r);
    op_run(OP_IDE_DMA_WR, 11'h3, 16'h5678, r);
    op_run(OP_IDE_PIO_RD, 11'h0, 16'h0, r);
    chk("pio read", 16'h5678, r);
    op_run(OP_IDE_CTL_WR, 11'h0, 16'h000A, r);
    op_run(OP_IDE_CTL_RD, 11'h6, 16'h0, r);
    chk("alt status read", 16'h000A, r);
  endtask
  task reinsert;
    pwr(1'b0);
    op_run(OP_MEM_WORD_RD, 11'h2, 16'h0, r);
    chk("pc read after reinsert", 16'hC377, r);
  endtask
  // Each configuration index places the offset in its own address window
  task cfg_maps;
    cfg_index = CFG_PRI;
    op_run(OP_MEM_WORD_RD, 11'h2, 16'h0, r);
    chk("primary read", 16'hC377, r);
    chk("primary addr", 16'h01F2, {5'h00, addr});
    cfg_index = CFG_SEC;
    op_run(OP_MEM_BYTE_RD, 11'h00F, 16'h0, r);
    chk("secondary ctl addr", 16'h0377, {5'h00, addr});
    cfg_index = CFG_CONTIG;
    op_run(OP_MEM_BYTE_RD, 11'h7A3, 16'h0, r);
    chk("contig read", 16'h00C3, r);
    chk("contig addr", 16'h07A3, {5'h00, addr});
    cfg_index = CFG_MEM;
    op_run(OP_MEM_BYTE_RD, 11'h403, 16'h0, r);
    chk("dup window read", 16'h00C3, r);
    chk("dup window addr", 16'h0403, {5'h00, addr});
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    pwr(1'b0);
    pc_lanes;
    ide_paths;
    reinsert;
    cfg_maps;
    end_sim;
  end
endmodule // tb_top
